/* File: dcm_bank_timer.sv */
// Per-bank row-cycle timers
`timescale 1ns/100ps
module dcm_bank_timer #(
	parameter int BANKS = 16,
	parameter int CW = 4
) (
	// Clock and reset
	input wire logic sys_clk_i,
	input wire logic resetn_i,
	// Bank command starts and row-cycle count
	input wire logic [BANKS-1:0] start_i,
	input wire logic [CW-1:0] count_i,
	// Banks still inside their row cycle
	output logic [BANKS-1:0] busy_o
);
	if (BANKS < 1 || CW < 1) begin : g_bad
		$error("dcm_bank_timer: BANKS and CW must be positive");
	end
	for (genvar b = 0; b < BANKS; b++) begin : g_bank
		logic [CW-1:0] cnt_q;
		always_ff @(posedge sys_clk_i or negedge resetn_i) begin
			if (!resetn_i) begin
				cnt_q <= '0;
			end else if (start_i[b]) begin
				cnt_q <= count_i;
			end else if (cnt_q != '0) begin
				cnt_q <= cnt_q - 1'b1;
			end
		end
		assign busy_o[b] = (cnt_q != '0);
		property p_load;
			@(posedge sys_clk_i) disable iff (!resetn_i)
			start_i[b] && count_i != '0 |=> busy_o[b] && cnt_q == $past(count_i);
		endproperty
		a_load: assert property (p_load) else $error("bank timer did not load");
		property p_expire;
			@(posedge sys_clk_i) disable iff (!resetn_i)
			cnt_q == 1 && !start_i[b] |=> !busy_o[b];
		endproperty
		a_expire: assert property (p_expire) else $error("bank timer did not expire");
	end
endmodule : dcm_bank_timer

/* File: dcm_cfg.svh */
// Register map, field positions, reset values and timing counts for the DRAM command controller
`ifndef DCM_CFG_SVH
`define DCM_CFG_SVH
`define DCM_OFF_CTRL 8'h00
`define DCM_OFF_ADDR 8'h04
`define DCM_OFF_BANK 8'h08
`define DCM_OFF_STAT 8'h0C
`define DCM_OFF_MR0 8'h10
`define DCM_OFF_MR1 8'h14
`define DCM_CTRL_GO 0
`define DCM_CTRL_CMD_LSB 1
`define DCM_CTRL_INIT 4
`define DCM_ST_BUSY 0
`define DCM_ST_REFUSED 1
`define DCM_ST_DLL_LOCK 2
`define DCM_ST_DLL_DUE 3
`define DCM_ST_CAL 4
`define DCM_MR0_LAT_LSB 4
`define DCM_MR0_DLL_EN 8
`define DCM_MR0_MUX 9
`define DCM_MR1_DLL_RST 5
`define DCM_MR1_CAL_LONG 6
`define DCM_MR1_CAL_GO 7
`define DCM_MR1_REF_MULTI 8
`define DCM_MR0_MASK 21'h0003FF
`define DCM_MR1_MASK 21'h0007FF
`define DCM_MR2_MASK 21'h0000FF
`define DCM_MR1_SELF_CLR 21'h0000A0
`define DCM_MR_RESET 21'h000000
`define DCM_RC_MIN 4'h3
`define DCM_DLL_LOCK_CYC 16'h0200
`define DCM_CAL_SHORT_CYC 16'h0040
`define DCM_REF_MAX_BANKS 5'h04
`endif

/* File: dcm_ctrl.sv */
// Host-side command and mode-register controller for a low-latency DRAM, with APB register port
`timescale 1ns/100ps
`include "dcm_cfg.svh"
module dcm_ctrl #(
	parameter int MRSC_CYC = 12,
	parameter int CAL_INIT_CYC = 16384,
	parameter int CAL_OPER_CYC = 1024
) (
	// Clock and reset
	input wire logic sys_clk_i,
	input wire logic resetn_i,
	// APB slave
	input wire logic psel_i,
	input wire logic penable_i,
	input wire logic pwrite_i,
	input wire logic [7:0] paddr_i,
	input wire logic [31:0] pwdata_i,
	output logic [31:0] prdata_o,
	output logic pready_o,
	output logic pslverr_o,
	// DRAM command and address pins
	output logic dram_cs_n_o,
	output logic dram_we_n_o,
	output logic dram_ref_n_o,
	output logic [20:0] dram_addr_o,
	output logic [3:0] dram_ba_o
);
	import dcm_pkg::*;

	if (MRSC_CYC < 1 || MRSC_CYC > 65535 || CAL_INIT_CYC < 1 || CAL_INIT_CYC > 65535 ||
		CAL_OPER_CYC < 1 || CAL_OPER_CYC > 65535) begin : g_bad
		$error("dcm_ctrl: wait counts must fit 16 bits and be nonzero");
	end

	function automatic logic [4:0] ones16(input logic [15:0] v);
		logic [4:0] n;
		n = 5'h00;
		for (int i = 0; i < 16; i++) begin
			n = n + {4'h0, v[i]};
		end
		return n;
	endfunction : ones16

	dcm_cmd_t cmd_q;
	dcm_state_t state_q;
	logic init_q, go_q, refused_q, dll_due_q, cal_q, mux_prev_q;
	logic [20:0] addr_q, mr0_q, mr1_q, ms_val;
	logic [3:0] bank_q, rc, lat;
	logic [15:0] wait_q, dll_q, wait_len, busy_w, busy_prev_q, oh, refm, start_v, start_w;
	logic [9:0] hi_q;
	logic [31:0] rdata_q;
	logic ok, issue, mux, busy, apb_wr, apb_setup_rd, mapped;

	assign apb_wr = psel_i && penable_i && pwrite_i;
	assign apb_setup_rd = psel_i && !penable_i && !pwrite_i;
	assign busy = (state_q != DCM_IDLE) || go_q;
	assign mux = mr0_q[`DCM_MR0_MUX];
	assign rc = addr_q[3:0];
	assign lat = addr_q[`DCM_MR0_LAT_LSB +: 4];
	assign refm = addr_q[15:0];
	assign oh = 16'h0001 << bank_q;
	assign mapped = (paddr_i[1:0] == 2'b00) && (paddr_i <= `DCM_OFF_MR1);

	// Zero-wait slave: read data is captured in the setup cycle
	assign pready_o = 1'b1;
	assign pslverr_o = psel_i && penable_i && !mapped;
	assign prdata_o = rdata_q;

	// Legality of the pending command and the banks it occupies
	always_comb begin
		ok = 1'b0;
		start_v = 16'h0000;
		unique case (bank_q[1:0])
			2'b00: ms_val = addr_q & `DCM_MR0_MASK;
			2'b01: ms_val = addr_q & `DCM_MR1_MASK;
			default: ms_val = addr_q & `DCM_MR2_MASK;
		endcase
		unique case (cmd_q)
			DCM_CMD_NOP: ok = 1'b1;
			DCM_CMD_MODE_SET: begin
				// Refusing a bad timing word here is cheaper than a hung memory
				ok = (busy_w == 16'h0000) && (bank_q[1:0] != 2'b11) &&
					!(bank_q[1:0] == 2'b00 && (rc < `DCM_RC_MIN ||
					(!addr_q[`DCM_MR0_DLL_EN] && rc != lat)));
			end
			DCM_CMD_READ: begin
				ok = ((busy_w & oh) == 16'h0000) && (dll_q == 16'h0000);
				start_v = oh;
			end
			DCM_CMD_WRITE: begin
				ok = ((busy_w & oh) == 16'h0000);
				start_v = oh;
			end
			DCM_CMD_AUTO_REFRESH: begin
				if (mr1_q[`DCM_MR1_REF_MULTI]) begin
					ok = (refm != 16'h0000) && (ones16(refm) <= `DCM_REF_MAX_BANKS) &&
						((refm & busy_w) == 16'h0000);
					start_v = refm;
				end else begin
					ok = ((busy_w & oh) == 16'h0000);
					start_v = oh;
				end
			end
			default: ok = 1'b0;
		endcase
	end

	assign issue = (state_q == DCM_IDLE) && go_q && ok;
	assign start_w = issue ? start_v : 16'h0000;

	// Calibration window if the write starts one, else plain mode-set recovery
	always_comb begin
		wait_len = 16'(MRSC_CYC);
		if (bank_q[1:0] == 2'b01 && addr_q[`DCM_MR1_CAL_GO]) begin
			if (!addr_q[`DCM_MR1_CAL_LONG]) begin
				wait_len = `DCM_CAL_SHORT_CYC;
			end else if (init_q) begin
				wait_len = 16'(CAL_INIT_CYC);
			end else begin
				wait_len = 16'(CAL_OPER_CYC);
			end
		end
	end

	dcm_bank_timer #(
		.BANKS(16),
		.CW(4)
	) u_timer (
		.sys_clk_i(sys_clk_i),
		.resetn_i(resetn_i),
		.start_i(start_w),
		.count_i(mr0_q[3:0]),
		.busy_o(busy_w)
	);

	// Software command registers
	always_ff @(posedge sys_clk_i or negedge resetn_i) begin
		if (!resetn_i) begin
			cmd_q <= DCM_CMD_NOP;
			init_q <= 1'b1;
			go_q <= 1'b0;
			addr_q <= 21'h000000;
			bank_q <= 4'h0;
		end else begin
			if (state_q == DCM_IDLE && go_q) begin
				go_q <= 1'b0;
			end
			if (apb_wr && paddr_i == `DCM_OFF_CTRL) begin
				init_q <= pwdata_i[`DCM_CTRL_INIT];
				if (pwdata_i[`DCM_CTRL_GO] && !busy) begin
					go_q <= 1'b1;
					cmd_q <= dcm_cmd_t'(pwdata_i[`DCM_CTRL_CMD_LSB +: 3]);
				end
			end
			if (apb_wr && paddr_i == `DCM_OFF_ADDR && !busy) begin
				addr_q <= pwdata_i[20:0];
			end
			if (apb_wr && paddr_i == `DCM_OFF_BANK && !busy) begin
				bank_q <= pwdata_i[3:0];
			end
		end
	end

	// Refused flag: a new refusal wins over a write-one-to-clear
	always_ff @(posedge sys_clk_i or negedge resetn_i) begin
		if (!resetn_i) begin
			refused_q <= 1'b0;
		end else if ((apb_wr && paddr_i == `DCM_OFF_CTRL && pwdata_i[`DCM_CTRL_GO] && busy) ||
			(state_q == DCM_IDLE && go_q && !ok)) begin
			refused_q <= 1'b1;
		end else if (apb_wr && paddr_i == `DCM_OFF_STAT && pwdata_i[`DCM_ST_REFUSED]) begin
			refused_q <= 1'b0;
		end
	end

	// Shadow copies of what the device holds
	always_ff @(posedge sys_clk_i or negedge resetn_i) begin
		if (!resetn_i) begin
			mr0_q <= `DCM_MR_RESET;
			mr1_q <= `DCM_MR_RESET;
		end else if (issue && cmd_q == DCM_CMD_MODE_SET) begin
			if (bank_q[1:0] == 2'b00) begin
				mr0_q <= ms_val;
			end
			if (bank_q[1:0] == 2'b01) begin
				mr1_q <= ms_val & ~`DCM_MR1_SELF_CLR;
			end
		end
	end

	// DLL lock wait and the pending-reset reminder; calibration may overlap it
	always_ff @(posedge sys_clk_i or negedge resetn_i) begin
		if (!resetn_i) begin
			dll_q <= 16'h0000;
			dll_due_q <= 1'b0;
		end else begin
			if (issue && cmd_q == DCM_CMD_MODE_SET && bank_q[1:0] == 2'b01 &&
				addr_q[`DCM_MR1_DLL_RST]) begin
				dll_q <= `DCM_DLL_LOCK_CYC;
				dll_due_q <= 1'b0;
			end else begin
				if (dll_q != 16'h0000) begin
					dll_q <= dll_q - 16'h0001;
				end
				if (issue && cmd_q == DCM_CMD_MODE_SET && bank_q[1:0] == 2'b00 &&
					addr_q[`DCM_MR0_DLL_EN]) begin
					dll_due_q <= 1'b1;
				end
			end
		end
	end

	// Sequencer: second address half, then recovery or calibration quiet time
	always_ff @(posedge sys_clk_i or negedge resetn_i) begin
		if (!resetn_i) begin
			state_q <= DCM_IDLE;
			wait_q <= 16'h0000;
			cal_q <= 1'b0;
			hi_q <= 10'h000;
		end else begin
			unique case (state_q)
				DCM_IDLE: begin
					if (issue && cmd_q != DCM_CMD_NOP) begin
						wait_q <= wait_len;
						cal_q <= (cmd_q == DCM_CMD_MODE_SET) && (bank_q[1:0] == 2'b01) &&
							addr_q[`DCM_MR1_CAL_GO];
						hi_q <= (cmd_q == DCM_CMD_MODE_SET) ? ms_val[20:11] : addr_q[20:11];
						if (mux && cmd_q != DCM_CMD_AUTO_REFRESH) begin
							state_q <= DCM_HALF2;
						end else if (cmd_q == DCM_CMD_MODE_SET) begin
							state_q <= DCM_WAIT;
						end
					end
				end
				DCM_HALF2: begin
					state_q <= (cmd_q == DCM_CMD_MODE_SET) ? DCM_WAIT : DCM_IDLE;
				end
				DCM_WAIT: begin
					// Holding pins at no-op here keeps the device from dropping a command
					wait_q <= wait_q - 16'h0001;
					if (wait_q == 16'h0001) begin
						state_q <= DCM_IDLE;
						cal_q <= 1'b0;
					end
				end
				default: state_q <= DCM_IDLE;
			endcase
		end
	end

	// Registered pins, stable from one rising edge to the next
	always_ff @(posedge sys_clk_i or negedge resetn_i) begin
		if (!resetn_i) begin
			dram_cs_n_o <= 1'b1;
			dram_we_n_o <= 1'b1;
			dram_ref_n_o <= 1'b1;
			dram_addr_o <= 21'h000000;
			dram_ba_o <= 4'h0;
		end else begin
			dram_cs_n_o <= 1'b1;
			dram_we_n_o <= 1'b1;
			dram_ref_n_o <= 1'b1;
			dram_addr_o <= 21'h000000;
			dram_ba_o <= 4'h0;
			if (state_q == DCM_HALF2) begin
				dram_addr_o <= {11'h000, hi_q};
			end else if (issue && cmd_q != DCM_CMD_NOP) begin
				dram_cs_n_o <= 1'b0;
				dram_we_n_o <= (cmd_q == DCM_CMD_READ) || (cmd_q == DCM_CMD_AUTO_REFRESH);
				dram_ref_n_o <= (cmd_q == DCM_CMD_READ) || (cmd_q == DCM_CMD_WRITE);
				unique case (cmd_q)
					DCM_CMD_MODE_SET: begin
						dram_addr_o <= mux ? {10'h000, ms_val[10:0]} : ms_val;
						dram_ba_o <= {2'b00, bank_q[1:0]};
					end
					DCM_CMD_AUTO_REFRESH: begin
						if (mr1_q[`DCM_MR1_REF_MULTI]) begin
							dram_addr_o <= {5'h00, refm};
						end else begin
							dram_ba_o <= bank_q;
						end
					end
					default: begin
						dram_addr_o <= mux ? {10'h000, addr_q[10:0]} : addr_q;
						dram_ba_o <= bank_q;
					end
				endcase
			end
		end
	end

	always_ff @(posedge sys_clk_i or negedge resetn_i) begin
		if (!resetn_i) begin
			rdata_q <= 32'h00000000;
		end else if (apb_setup_rd) begin
			unique case (paddr_i)
				`DCM_OFF_CTRL: rdata_q <= {27'h0000000, init_q, cmd_q, 1'b0};
				`DCM_OFF_ADDR: rdata_q <= {11'h000, addr_q};
				`DCM_OFF_BANK: rdata_q <= {28'h0000000, bank_q};
				`DCM_OFF_STAT: rdata_q <= {27'h0000000, cal_q, dll_due_q, dll_q != 16'h0000, refused_q, busy};
				`DCM_OFF_MR0: rdata_q <= {11'h000, mr0_q};
				`DCM_OFF_MR1: rdata_q <= {11'h000, mr1_q};
				default: rdata_q <= 32'h00000000;
			endcase
		end
	end

	// Helpers read only by the checks below
	logic [15:0] wait_cnt_h;
	logic pin_ms, pin_rd, pin_wr, pin_ref, in_wait;
	assign pin_ms = !dram_cs_n_o && !dram_we_n_o && !dram_ref_n_o;
	assign pin_rd = !dram_cs_n_o && dram_we_n_o && dram_ref_n_o;
	assign pin_wr = !dram_cs_n_o && !dram_we_n_o && dram_ref_n_o;
	assign pin_ref = !dram_cs_n_o && dram_we_n_o && !dram_ref_n_o;
	assign in_wait = (state_q == DCM_WAIT);
	always_ff @(posedge sys_clk_i or negedge resetn_i) begin
		if (!resetn_i) begin
			wait_cnt_h <= 16'h0000;
			busy_prev_q <= 16'h0000;
			mux_prev_q <= 1'b0;
		end else begin
			wait_cnt_h <= in_wait ? wait_cnt_h + 16'h0001 : 16'h0000;
			busy_prev_q <= busy_w;
			mux_prev_q <= mux;
		end
	end

	default clocking cb @(posedge sys_clk_i); endclocking
	default disable iff (!resetn_i);

	// The mode set itself, or its second address half when muxed, is still on the pins in the first wait cycle
	property p_wait_quiet;
		in_wait && $past(in_wait) |-> dram_cs_n_o;
	endproperty
	a_wait_quiet: assert property (p_wait_quiet) else $error("command during recovery");
	property p_ms_recover;
		pin_ms |-> ##[1:2] in_wait;
	endproperty
	a_ms_recover: assert property (p_ms_recover) else $error("no recovery after mode set");
	property p_recover_len;
		$fell(in_wait) && !$past(cal_q) |-> wait_cnt_h == MRSC_CYC;
	endproperty
	a_recover_len: assert property (p_recover_len) else $error("recovery length wrong");
	property p_ms_ba;
		pin_ms |-> dram_ba_o[3:2] == 2'b00;
	endproperty
	a_ms_ba: assert property (p_ms_ba) else $error("high bank bits set in mode set");
	property p_ms_rsv;
		pin_ms && dram_ba_o[1:0] == 2'b00 |-> (dram_addr_o & ~`DCM_MR0_MASK) == 21'h000000;
	endproperty
	a_ms_rsv: assert property (p_ms_rsv) else $error("reserved bit set in mode set");
	property p_bank_rc;
		pin_rd || pin_wr || (pin_ref && !mr1_q[`DCM_MR1_REF_MULTI]) |-> !busy_prev_q[dram_ba_o];
	endproperty
	a_bank_rc: assert property (p_bank_rc) else $error("bank reused inside row cycle");
	property p_ref_multi;
		pin_ref && mr1_q[`DCM_MR1_REF_MULTI] |->
			(dram_addr_o[15:0] & busy_prev_q) == 16'h0000 && $countones(dram_addr_o[15:0]) inside {[1:4]};
	endproperty
	a_ref_multi: assert property (p_ref_multi) else $error("bad multibank refresh");
	property p_dll_read;
		pin_rd |-> dll_q == 16'h0000;
	endproperty
	a_dll_read: assert property (p_dll_read) else $error("read during DLL lock");
	property p_dll_load;
		pin_ms && dram_ba_o[1:0] == 2'b01 && dram_addr_o[`DCM_MR1_DLL_RST] |-> dll_q == `DCM_DLL_LOCK_CYC;
	endproperty
	a_dll_load: assert property (p_dll_load) else $error("DLL wait not started");
	property p_mux_half;
		(pin_rd || pin_wr) && mux_prev_q |=> dram_cs_n_o && dram_addr_o[20:10] == 11'h000;
	endproperty
	a_mux_half: assert property (p_mux_half) else $error("second address half wrong");
	property p_cal_quiet;
		cal_q && $past(cal_q) |-> dram_cs_n_o;
	endproperty
	a_cal_quiet: assert property (p_cal_quiet) else $error("channel busy in calibration");

	property p_cov_mux_read;
		pin_rd && mux_prev_q;
	endproperty
	c_mux_read: cover property (p_cov_mux_read);
	property p_cov_cal;
		$rose(cal_q);
	endproperty
	c_cal: cover property (p_cov_cal);
	property p_cov_multi_ref;
		pin_ref && mr1_q[`DCM_MR1_REF_MULTI];
	endproperty
	c_multi_ref: cover property (p_cov_multi_ref);
endmodule : dcm_ctrl

/* File: dcm_ctrl_tb.sv */
// Self-checking testbench for the DRAM command controller
`timescale 1ns/100ps
`include "dcm_cfg.svh"
module dcm_ctrl_tb;
	logic sys_clk;
	logic resetn;
	logic psel;
	logic penable;
	logic pwrite;
	logic [7:0] paddr;
	logic [31:0] pwdata;
	logic [31:0] prdata;
	logic pready;
	logic pslverr;
	logic cs_n;
	logic we_n;
	logic ref_n;
	logic [20:0] addr;
	logic [3:0] ba;
	logic [20:0] mr0;
	logic [20:0] mr1;
	logic [2:0] last_cmd;
	logic [20:0] last_addr;
	logic [3:0] last_ba;
	logic [20:0] next_addr;
	int cmd_cnt;
	int viol;
	int err_count;
	int compares;
	logic init_ph;
	logic perr;
	logic [31:0] rdat;
	logic [20:0] a;
	logic [3:0] b;
	logic [3:0] lat;
	logic [15:0] m;
	dcm_ctrl #(.MRSC_CYC(2), .CAL_INIT_CYC(32), .CAL_OPER_CYC(16)) i_dut (.sys_clk_i(sys_clk), .resetn_i(resetn),
		.psel_i(psel), .penable_i(penable), .pwrite_i(pwrite), .paddr_i(paddr), .pwdata_i(pwdata), .prdata_o(prdata),
		.pready_o(pready), .pslverr_o(pslverr), .dram_cs_n_o(cs_n), .dram_we_n_o(we_n), .dram_ref_n_o(ref_n),
		.dram_addr_o(addr), .dram_ba_o(ba));
	dcm_dram_model #(.MRSC_CYC(2), .CAL_OPER_CYC(16)) i_dram (.sys_clk_i(sys_clk), .resetn_i(resetn), .cs_n_i(cs_n),
		.we_n_i(we_n), .ref_n_i(ref_n), .addr_i(addr), .ba_i(ba), .mr0_o(mr0), .mr1_o(mr1), .last_cmd_o(last_cmd),
		.last_addr_o(last_addr), .last_ba_o(last_ba), .next_addr_o(next_addr), .cmd_cnt_o(cmd_cnt), .viol_o(viol));
	initial begin
		sys_clk = 1'b0;
		forever #2 sys_clk = ~sys_clk;
	end
	task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
		compares++;
		if (got !== exp) begin
			err_count++;
			$display("[FAIL] %s expected %h seen %h", what, exp, got);
		end
	endtask : chk
	// Request is held from setup until pready is seen high at an edge
	task automatic apb(input logic wr_en, input logic [7:0] ad, input logic [31:0] d, output logic [31:0] q);
		@(posedge sys_clk);
		psel <= 1'b1;
		pwrite <= wr_en;
		paddr <= ad;
		pwdata <= d;
		@(posedge sys_clk);
		penable <= 1'b1;
		@(posedge sys_clk);
		while (pready !== 1'b1) @(posedge sys_clk);
		q = prdata;
		perr = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask : apb
	task automatic wr(input logic [7:0] ad, input logic [31:0] d);
		logic [31:0] q;
		apb(1'b1, ad, d, q);
	endtask : wr
	task automatic rd(input logic [7:0] ad, output logic [31:0] q);
		apb(1'b0, ad, 32'h0, q);
	endtask : rd
	task automatic setab(input logic [20:0] ad, input logic [3:0] bk);
		wr(`DCM_OFF_ADDR, {11'h0, ad});
		wr(`DCM_OFF_BANK, {28'h0, bk});
	endtask : setab
	// Launch a command, wait for idle, then check what reached the pins and the refusal flag
	task automatic go(input logic [2:0] c, input logic shown, input logic refused);
		int n0;
		int k;
		n0 = cmd_cnt;
		k = 0;
		wr(`DCM_OFF_CTRL, {27'h0, init_ph, c, 1'b1});
		do begin
			rd(`DCM_OFF_STAT, rdat);
			k++;
		end while (rdat[`DCM_ST_BUSY] !== 1'b0 && k < 300);
		chk("command count", 32'(shown), 32'(cmd_cnt - n0));
		chk("refused flag", 32'(refused), 32'(rdat[`DCM_ST_REFUSED]));
		if (rdat[`DCM_ST_REFUSED] === 1'b1) wr(`DCM_OFF_STAT, 32'h2);
	endtask : go
	task automatic give_verdict();
		$display("comparisons %0d mismatches %0d", compares, err_count);
		if (err_count == 0 && compares > 0) $display("*** PASS ***");
		else $display("*** FAIL ***");
		$finish;
	endtask : give_verdict
	initial begin
		repeat (20000) @(posedge sys_clk);
		err_count++;
		$display("[FAIL] watchdog expected finish seen timeout");
		give_verdict();
	end
	initial begin
		resetn = 1'b0;
		psel = 1'b0;
		penable = 1'b0;
		pwrite = 1'b0;
		paddr = 8'h00;
		pwdata = 32'h0;
		init_ph = 1'b1;
		err_count = 0;
		compares = 0;
		void'($urandom(32'h2958));
		repeat (3) @(posedge sys_clk);
		resetn <= 1'b1;
		rd(`DCM_OFF_CTRL, rdat);
		chk("ctrl reset", 32'h10, rdat);
		rd(`DCM_OFF_MR1, rdat);
		chk("mr1 reset", 32'h0, rdat);
		rd(8'h18, rdat);
		chk("unmapped error", 32'h1, {31'h0, perr});
		chk("unmapped data", 32'h0, rdat);
		// Illegal mode sets first: select 3, short row cycle, DLL off with mismatched count
		lat = 4'($urandom_range(15, 4));
		setab({11'h0, 2'b01, lat, 4'h5}, 4'h3);
		go(3'h1, 1'b0, 1'b1);
		setab({11'h0, 2'b01, lat, 4'h2}, 4'h0);
		go(3'h1, 1'b0, 1'b1);
		setab({11'h0, 2'b00, lat, lat ^ 4'h1}, 4'h0);
		go(3'h1, 1'b0, 1'b1);
		a = {11'h0, 2'b00, lat, lat};
		setab(a, 4'hC);
		go(3'h1, 1'b1, 1'b0);
		chk("mode set bank pins", 32'h0, 32'(last_ba));
		chk("mr0 dll off", 32'(a), 32'(mr0));
		a = {11'h0, 2'b01, lat, 4'hF};
		setab(a, 4'h0);
		go(3'h1, 1'b1, 1'b0);
		rd(`DCM_OFF_MR0, rdat);
		chk("mr0 shadow", 32'(a), rdat);
		rd(`DCM_OFF_STAT, rdat);
		chk("dll reset due", 32'h8, rdat & 32'h8);
		b = 4'($urandom);
		for (int c = 0; c < 8; c++) begin
			if (c == 1) continue;
			a = 21'($urandom);
			setab(a, b + 4'(c));
			go(3'(c), c >= 2 && c <= 4, c >= 5);
			if (c == 2 || c == 3) chk("rw address", 32'(a), 32'(last_addr));
			if (c >= 2 && c <= 4) chk("bank pins", 32'(4'(b + 4'(c))), 32'(last_ba));
			if (c >= 2 && c <= 4) chk("command", 32'(c), 32'(last_cmd));
		end
		a = 21'($urandom);
		setab(a, {b[3:2], 2'b01});
		go(3'h2, 1'b1, 1'b0);
		go(3'h2, 1'b0, 1'b1);
		go(3'h1, 1'b0, 1'b1);
		repeat (16) @(posedge sys_clk);
		go(3'h2, 1'b1, 1'b0);
		repeat (16) @(posedge sys_clk);
		a = {12'h0, 4'h1, 5'($urandom)};
		setab(a, 4'h1);
		go(3'h1, 1'b1, 1'b0);
		chk("mr1 model", 32'(a & ~21'h20), 32'(mr1));
		rd(`DCM_OFF_MR1, rdat);
		chk("mr1 shadow", 32'(a & ~21'h20), rdat);
		rd(`DCM_OFF_STAT, rdat);
		chk("dll lock wait", 32'h4, rdat & 32'h4);
		setab(21'($urandom), 4'h2);
		go(3'h2, 1'b0, 1'b1);
		repeat (520) @(posedge sys_clk);
		go(3'h2, 1'b1, 1'b0);
		repeat (16) @(posedge sys_clk);
		setab({12'h0, 4'hC, 5'h00}, 4'h1);
		go(3'h1, 1'b1, 1'b0);
		chk("cal bit cleared", 32'h100, 32'(mr1));
		for (int i = 0; i < 3; i++) begin
			m = (i == 0) ? 16'h001F : (i == 1) ? 16'h0000 : 16'h1111 << $urandom_range(3, 0);
			setab({5'h0, m}, 4'h0);
			go(3'h4, i == 2, i != 2);
		end
		chk("refresh mask", 32'(m), 32'(last_addr[15:0]));
		repeat (16) @(posedge sys_clk);
		setab({11'h0, 2'b11, lat, 4'h3}, 4'h0);
		go(3'h1, 1'b1, 1'b0);
		a = 21'($urandom);
		b = 4'($urandom);
		setab(a, b);
		go(3'h2, 1'b1, 1'b0);
		chk("first half", 32'(a[10:0]), 32'(last_addr[10:0]));
		chk("second half", 32'(a[20:11]), 32'(next_addr[9:0]));
		chk("mux bank", 32'(b), 32'(last_ba));
		chk("device violations", 32'h0, 32'(viol));
		resetn <= 1'b0;
		repeat (2) @(posedge sys_clk);
		resetn <= 1'b1;
		rd(`DCM_OFF_MR0, rdat);
		chk("mr0 after reset", 32'h0, rdat);
		chk("device mr0 after reset", 32'h0, 32'(mr0));
		give_verdict();
	end
endmodule : dcm_ctrl_tb

/* File: dcm_dram_model.sv */
// Behavioural model of the DRAM device: command decode, mode registers and timing checks
`timescale 1ns/100ps
`include "dcm_cfg.svh"
module dcm_dram_model #(
	parameter int MRSC_CYC = 2,
	parameter int CAL_OPER_CYC = 16
) (
	// Clock and reset
	input wire logic sys_clk_i,
	input wire logic resetn_i,
	// Command and address pins
	input wire logic cs_n_i,
	input wire logic we_n_i,
	input wire logic ref_n_i,
	input wire logic [20:0] addr_i,
	input wire logic [3:0] ba_i,
	// Observed device state
	output logic [20:0] mr0_o,
	output logic [20:0] mr1_o,
	output logic [2:0] last_cmd_o,
	output logic [20:0] last_addr_o,
	output logic [3:0] last_ba_o,
	output logic [20:0] next_addr_o,
	output int cmd_cnt_o,
	output int viol_o
);
	import dcm_pkg::*;
	dcm_cmd_t cmd;
	logic [15:0] bmask;
	logic [15:0] busy;
	logic [20:0] mr2_q;
	logic seen_q;
	logic bad;
	int quiet_q;
	int dll_q;
	int tmr_q [16];
	always_comb begin
		if (cs_n_i) cmd = DCM_CMD_NOP;
		else if (!we_n_i && !ref_n_i) cmd = DCM_CMD_MODE_SET;
		else if (we_n_i && ref_n_i) cmd = DCM_CMD_READ;
		else if (!we_n_i) cmd = DCM_CMD_WRITE;
		else cmd = DCM_CMD_AUTO_REFRESH;
		bmask = 16'h0001 << ba_i;
		if (cmd == DCM_CMD_AUTO_REFRESH && mr1_o[`DCM_MR1_REF_MULTI]) bmask = addr_i[15:0];
		foreach (tmr_q[i]) busy[i] = (tmr_q[i] != 0);
		// A mode set is judged whole: busy banks, stray bank bits, bad select, DLL-off count mismatch
		bad = (|busy) || ba_i[3:2] != 2'b00 || ba_i[1:0] == 2'b11;
		bad = bad || (ba_i[1:0] == 2'b00 && !addr_i[8] && addr_i[3:0] != addr_i[7:4]);
	end
	always_ff @(posedge sys_clk_i or negedge resetn_i) begin
		if (!resetn_i) begin
			mr0_o <= `DCM_MR_RESET;
			mr1_o <= `DCM_MR_RESET;
			mr2_q <= `DCM_MR_RESET;
			last_cmd_o <= 3'h0;
			last_addr_o <= 21'h000000;
			last_ba_o <= 4'h0;
			next_addr_o <= 21'h000000;
			seen_q <= 1'b0;
			cmd_cnt_o <= 0;
			viol_o <= 0;
			quiet_q <= 0;
			dll_q <= 0;
			foreach (tmr_q[i]) tmr_q[i] <= 0;
		end else begin
			seen_q <= (cmd != DCM_CMD_NOP);
			if (seen_q) next_addr_o <= addr_i;
			if (quiet_q != 0) quiet_q <= quiet_q - 1;
			if (quiet_q == 1) mr1_o[`DCM_MR1_CAL_GO] <= 1'b0;
			if (dll_q != 0) dll_q <= dll_q - 1;
			foreach (tmr_q[i]) if (tmr_q[i] != 0) tmr_q[i] <= tmr_q[i] - 1;
			if (cmd != DCM_CMD_NOP) begin
				cmd_cnt_o <= cmd_cnt_o + 1;
				last_cmd_o <= cmd;
				last_addr_o <= addr_i;
				last_ba_o <= ba_i;
			end
			if (cmd != DCM_CMD_NOP && quiet_q != 0) viol_o <= viol_o + 1;
			else if (cmd == DCM_CMD_MODE_SET) begin
				if (bad) viol_o <= viol_o + 1;
				quiet_q <= MRSC_CYC;
				case (ba_i[1:0])
					2'b00: mr0_o <= addr_i;
					2'b01: begin
						mr1_o <= addr_i & ~21'h000020;
						if (addr_i[`DCM_MR1_DLL_RST]) dll_q <= 511;
						// Short window is the full 64 cycles; long uses the shorter operational one
						if (addr_i[`DCM_MR1_CAL_GO]) quiet_q <= addr_i[`DCM_MR1_CAL_LONG] ? CAL_OPER_CYC : 64;
					end
					2'b10: mr2_q <= addr_i;
					default: mr2_q <= mr2_q;
				endcase
			end else if (cmd != DCM_CMD_NOP) begin
				foreach (tmr_q[i]) if (bmask[i]) tmr_q[i] <= int'(mr0_o[3:0]) - 1;
				if ((bmask & busy) != 16'h0000 || $countones(bmask) > 4) viol_o <= viol_o + 1;
				else if (cmd == DCM_CMD_READ && dll_q != 0) viol_o <= viol_o + 1;
			end
		end
	end
endmodule : dcm_dram_model

/* File: dcm_pkg.sv */
// Types shared by the DRAM command controller
package dcm_pkg;
	typedef enum logic [2:0] {
		DCM_CMD_NOP = 3'b000,
		DCM_CMD_MODE_SET = 3'b001,
		DCM_CMD_READ = 3'b010,
		DCM_CMD_WRITE = 3'b011,
		DCM_CMD_AUTO_REFRESH = 3'b100
	} dcm_cmd_t;
	typedef enum logic [1:0] {
		DCM_IDLE = 2'b00,
		DCM_HALF2 = 2'b01,
		DCM_WAIT = 2'b10
	} dcm_state_t;
endpackage : dcm_pkg
